// file: rtl/pmg_power_ctrl.sv
// Power mode sequencer, wake pattern and shared pin control.
// Assumes comparator outputs arrive synchronous to clk, bus and pin levels are synchronised here, and that
// the two-wire slave presents register accesses on a simple strobe port.
`timescale 1ns/10ps

module pmg_power_ctrl
    import pmg_pkg::*;
#(
    parameter int DEBOUNCE_CYC = PMG_DEBOUNCE_CYC,
    parameter int RAMP_CYC = PMG_RAMP_CYC,
    parameter int ON_CYC = PMG_ON_CYC,
    parameter int OFF_CYC = PMG_OFF_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus line and shared pin levels
    input wire logic scl_level,
    input wire logic sda_level,
    input wire logic shared_pin_in,
    // Supply comparators
    input wire logic supply_above_cutoff,
    input wire logic supply_above_monitor,
    // Settings held elsewhere in the register file
    input wire pmg_blocks_t block_cfg,
    input wire logic [3:0] ext_pwm_channel_sel,
    input wire logic monitor_enable,
    input wire logic [5:0] monitor_level_cfg,
    // Register port from the two-wire slave
    input wire pmg_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // Mode and block enables
    output pmg_mode_t mode,
    output logic bus_if_enable,
    output pmg_blocks_t block_enable,
    output logic supply_monitor_on,
    output logic [5:0] supply_monitor_level,
    output logic supply_low,
    // LED drive
    output logic [3:0] led_pwm_gate,
    output logic led_one_wake_sel,
    output logic [7:0] led_one_wake_current,
    output logic [7:0] led_one_wake_level,
    // Shared pin
    output logic shared_pin_out,
    output logic shared_pin_oe,
    output logic shared_pin_digital_en,
    output logic shared_pin_pulldown_en
);

    // ----------------------------------------
    // Synchronisers
    // ----------------------------------------
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic [1:0] pin_sync_reg;
    logic scl_s;
    logic sda_s;
    logic pin_s;

    always_ff @(posedge clk) begin
        if (rst) begin
            scl_sync_reg <= 2'h0;
            sda_sync_reg <= 2'h0;
            pin_sync_reg <= 2'h0;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_level};
            sda_sync_reg <= {sda_sync_reg[0], sda_level};
            pin_sync_reg <= {pin_sync_reg[0], shared_pin_in};
        end
    end

    assign scl_s = scl_sync_reg[1];
    assign sda_s = sda_sync_reg[1];
    assign pin_s = pin_sync_reg[1];

    // ----------------------------------------
    // Bus line debounce
    // ----------------------------------------
    // Long filter so that ordinary bus traffic never looks like a power change
    logic [PMG_CNT_W-1:0] high_cnt_reg;
    logic [PMG_CNT_W-1:0] low_cnt_reg;
    logic lines_up;
    logic lines_down;

    function automatic logic [PMG_CNT_W-1:0] sat_inc(input logic [PMG_CNT_W-1:0] cnt, input int lim);
        logic [PMG_CNT_W-1:0] top;
        top = PMG_CNT_W'(lim);
        sat_inc = (cnt >= top) ? top : cnt + 1'b1;
    endfunction

    always_ff @(posedge clk) begin
        if (rst) begin
            high_cnt_reg <= '0;
            low_cnt_reg <= '0;
        end else begin
            high_cnt_reg <= (scl_s && sda_s) ? sat_inc(high_cnt_reg, DEBOUNCE_CYC) : '0;
            low_cnt_reg <= (!scl_s && !sda_s) ? sat_inc(low_cnt_reg, DEBOUNCE_CYC) : '0;
        end
    end

    assign lines_up = (high_cnt_reg >= PMG_CNT_W'(DEBOUNCE_CYC));
    assign lines_down = (low_cnt_reg >= PMG_CNT_W'(DEBOUNCE_CYC));

    // ----------------------------------------
    // Mode state machine
    // ----------------------------------------
    pmg_mode_t mode_reg;
    pmg_mode_t mode_next;
    logic any_block_cfg;

    assign any_block_cfg = block_cfg.charge_pump || (|block_cfg.current) || block_cfg.pattern || block_cfg.ext_pwm;

    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            PMG_OFF: begin
                if (lines_up) begin
                    mode_next = PMG_STANDBY;
                end else if (pin_s && !scl_s && !sda_s) begin
                    mode_next = PMG_PIN_WAKE;
                end
            end
            PMG_STANDBY: begin
                if (lines_down && !pin_s) begin
                    mode_next = PMG_OFF;
                end else if (lines_down) begin
                    mode_next = PMG_PIN_WAKE;
                end else if (any_block_cfg) begin
                    mode_next = PMG_ACTIVE;
                end
            end
            PMG_ACTIVE: begin
                if (lines_down && !pin_s) begin
                    mode_next = PMG_OFF;
                end else if (!any_block_cfg && !lines_down) begin
                    mode_next = PMG_STANDBY;
                end
            end
            PMG_PIN_WAKE: begin
                if (!pin_s) begin
                    mode_next = lines_up ? PMG_STANDBY : PMG_OFF;
                end
            end
            default: begin
                mode_next = PMG_OFF;
            end
        endcase
        // Cutoff has priority over everything and has no disable
        if (!supply_above_cutoff) begin
            mode_next = PMG_OFF;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg <= PMG_OFF;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // ----------------------------------------
    // Block enables
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            mode <= PMG_OFF;
            bus_if_enable <= 1'b0;
            block_enable <= '0;
        end else begin
            mode <= mode_next;
            bus_if_enable <= (mode_next != PMG_OFF);
            // Bus wake plus held pin keeps user settings running
            block_enable <= (mode_next == PMG_ACTIVE) ? block_cfg : '0;
        end
    end

    // ----------------------------------------
    // Supply monitor
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            supply_monitor_on <= 1'b0;
            supply_monitor_level <= PMG_MON_LEVEL_RESET;
            supply_low <= 1'b0;
        end else begin
            supply_monitor_on <= monitor_enable && (mode_next != PMG_OFF);
            // Codes below the floor are clamped rather than ignored
            supply_monitor_level <= (monitor_level_cfg < PMG_MON_LEVEL_MIN) ? PMG_MON_LEVEL_MIN
                                                                           : monitor_level_cfg;
            supply_low <= monitor_enable && supply_monitor_on && !supply_above_monitor;
        end
    end

    // ----------------------------------------
    // Wake pattern sequencer
    // ----------------------------------------
    pmg_phase_t phase_reg;
    logic [PMG_CNT_W-1:0] phase_cnt_reg;
    logic [PMG_CNT_W-1:0] step_cnt_reg;
    logic [7:0] level_reg;
    logic step_due;
    logic pattern_run;
    logic pattern_next;

    localparam int STEP_CYC = (RAMP_CYC / PMG_LEVEL_MAX) < 1 ? 1 : RAMP_CYC / PMG_LEVEL_MAX;

    assign pattern_run = (mode_reg == PMG_PIN_WAKE);
    // Outputs track the next mode so they change on the same edge as mode
    assign pattern_next = (mode_next == PMG_PIN_WAKE);
    assign step_due = (step_cnt_reg >= PMG_CNT_W'(STEP_CYC - 1));

    always_ff @(posedge clk) begin
        if (rst || !pattern_run) begin
            step_cnt_reg <= '0;
        end else begin
            step_cnt_reg <= step_due ? '0 : step_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !pattern_run) begin
            phase_reg <= PMG_RAMP_UP;
            phase_cnt_reg <= '0;
            level_reg <= 8'h00;
        end else begin
            case (phase_reg)
                PMG_RAMP_UP: begin
                    if (step_due) begin
                        level_reg <= level_reg + 8'h01;
                    end
                    if (step_due && level_reg == 8'(PMG_LEVEL_MAX - 1)) begin
                        phase_reg <= PMG_ON_HOLD;
                    end
                end
                PMG_ON_HOLD: begin
                    if (phase_cnt_reg >= PMG_CNT_W'(ON_CYC - 1)) begin
                        phase_cnt_reg <= '0;
                        phase_reg <= PMG_RAMP_DOWN;
                    end else begin
                        phase_cnt_reg <= phase_cnt_reg + 1'b1;
                    end
                end
                PMG_RAMP_DOWN: begin
                    if (step_due) begin
                        level_reg <= level_reg - 8'h01;
                    end
                    if (step_due && level_reg == 8'h01) begin
                        phase_reg <= PMG_OFF_HOLD;
                    end
                end
                PMG_OFF_HOLD: begin
                    if (phase_cnt_reg >= PMG_CNT_W'(OFF_CYC - 1)) begin
                        phase_cnt_reg <= '0;
                        phase_reg <= PMG_RAMP_UP;
                    end else begin
                        phase_cnt_reg <= phase_cnt_reg + 1'b1;
                    end
                end
                default: begin
                    phase_reg <= PMG_RAMP_UP;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            led_one_wake_sel <= 1'b0;
            led_one_wake_current <= 8'h00;
            led_one_wake_level <= 8'h00;
        end else begin
            led_one_wake_sel <= pattern_next;
            led_one_wake_current <= pattern_next ? PMG_WAKE_CURRENT : 8'h00;
            led_one_wake_level <= pattern_next ? level_reg : 8'h00;
        end
    end

    // ----------------------------------------
    // Shared pin registers
    // ----------------------------------------
    logic [2:0] pin_ctrl_reg;
    logic pin_out_reg;
    logic pin_digital;
    logic bus_wr;

    // Register writes need standby or active mode; pin wake keeps the bus interface on but drops them
    assign bus_wr = reg_req.wr_en && (mode_reg != PMG_OFF) && (mode_reg != PMG_PIN_WAKE);

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_ctrl_reg <= PMG_CTRL_RESET[2:0];
            pin_out_reg <= PMG_OUT_RESET[PMG_OUT_LEVEL_BIT];
        end else begin
            if (bus_wr && reg_req.addr == PMG_OFS_PIN_CTRL) begin
                pin_ctrl_reg <= reg_req.wdata[2:0];
            end
            if (bus_wr && reg_req.addr == PMG_OFS_PIN_OUT) begin
                pin_out_reg <= reg_req.wdata[PMG_OUT_LEVEL_BIT];
            end
        end
    end

    // Analog mode turns the digital receiver off, so the level reads zero
    assign pin_digital = pin_ctrl_reg[PMG_CTRL_DIGITAL_BIT] &&
                         (pin_s ^ pin_ctrl_reg[PMG_CTRL_INVERT_BIT]);

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_req.addr)
                PMG_OFS_PIN_CTRL: reg_rdata <= {5'h00, pin_ctrl_reg};
                PMG_OFS_PIN_OUT: reg_rdata <= {7'h00, pin_out_reg};
                PMG_OFS_PIN_LEVEL: reg_rdata <= {7'h00, pin_digital};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // Shared pin drive
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            shared_pin_out <= 1'b0;
            shared_pin_oe <= 1'b0;
            shared_pin_digital_en <= 1'b1;
            shared_pin_pulldown_en <= 1'b1;
        end else begin
            // Never drives high: a one only releases the pin
            shared_pin_out <= 1'b0;
            shared_pin_oe <= pin_ctrl_reg[PMG_CTRL_OUTPUT_BIT] && !pin_out_reg;
            shared_pin_digital_en <= pin_ctrl_reg[PMG_CTRL_DIGITAL_BIT];
            shared_pin_pulldown_en <= pin_ctrl_reg[PMG_CTRL_DIGITAL_BIT];
        end
    end

    // ----------------------------------------
    // External PWM gating
    // ----------------------------------------
    // Sync path adds three cycles of delay, fine against a 1 MHz input
    always_ff @(posedge clk) begin
        if (rst) begin
            led_pwm_gate <= 4'h0;
        end else if (mode_next == PMG_ACTIVE && block_cfg.ext_pwm && !pin_ctrl_reg[PMG_CTRL_OUTPUT_BIT]) begin
            led_pwm_gate <= ext_pwm_channel_sel & {4{pin_digital}};
        end else begin
            led_pwm_gate <= 4'hf;
        end
    end

endmodule

// file: rtl/pmg_pkg.sv
// Constants, register map and carrier types for the power mode and shared pin control block.
// Assumes a 20 MHz clock and a register port fed by the two-wire slave logic.
//
// Operation
// - Both bus lines low past debounce and shared pin low: enter shutdown.
// - Both bus lines high past debounce: move from off to standby.
// - Bus lines are debounced about 130 ms before standby and shutdown decisions; pin wake from off samples them undebounced.
// - Standby goes active as soon as any block is enabled.
// - Blocks follow their settings in active; all disabled in off and standby.
// - Pin high with bus lines low wakes device into the channel one pattern.
// - Bus wake with pin low enters standby and accepts configuration.
// - Bus lines falling while pin high keeps the device running.
// - After a pin wake, pin returning low shuts the device down, or enters standby if bus lines are up.
// - Supply below cutoff forces off from any mode; never disableable.
// - Second supply monitor: register enable, level 3.4 V default, down to 2.4 V.
// - Wake pattern: 2.62 s ramp up and down, 49 ms on, 0.54 s off.
// - Wake pattern drives channel one only, at 6.4 mA; others stay off.
// - External PWM on the shared pin modulates any channel, up to 1 MHz.
// - Shared pin output only pulls low or releases; far side supplies pull-up.
// - Internal pull-down is off whenever audio mode is in use.
// - Control bit 2 inverts the sampled digital input level.
// - Control bit 1 selects digital input (1, reset) or analog audio (0).
// - Control bit 0 selects input (0, reset) or open-drain output (1).
// - Level register bit 0 reads 1 when the pin is high, 0 when grounded.
// - Output register bit 0 updates the pin: 0 pulls low, 1 releases.
package pmg_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] PMG_OFS_PIN_CTRL = 8'h06;
    localparam logic [7:0] PMG_OFS_PIN_OUT = 8'h07;
    localparam logic [7:0] PMG_OFS_PIN_LEVEL = 8'h08;
    localparam int PMG_CTRL_INVERT_BIT = 2;
    localparam int PMG_CTRL_DIGITAL_BIT = 1;
    localparam int PMG_CTRL_OUTPUT_BIT = 0;
    localparam int PMG_OUT_LEVEL_BIT = 0;
    localparam logic [7:0] PMG_CTRL_RESET = 8'h02;
    localparam logic [7:0] PMG_OUT_RESET = 8'h00;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int PMG_CLK_MHZ = 20;
    localparam int PMG_DEBOUNCE_US = 130000;
    localparam int PMG_RAMP_US = 2620000;
    localparam int PMG_ON_US = 49000;
    localparam int PMG_OFF_US = 540000;
    localparam int PMG_DEBOUNCE_CYC = PMG_DEBOUNCE_US * PMG_CLK_MHZ;
    localparam int PMG_RAMP_CYC = PMG_RAMP_US * PMG_CLK_MHZ;
    localparam int PMG_ON_CYC = PMG_ON_US * PMG_CLK_MHZ;
    localparam int PMG_OFF_CYC = PMG_OFF_US * PMG_CLK_MHZ;
    localparam int PMG_CNT_W = 27;
    localparam int PMG_LEVEL_MAX = 255;

    // ----------------------------------------
    // Analog codes
    // ----------------------------------------
    // Channel one current in 0.1 mA steps: 6.4 mA
    localparam logic [7:0] PMG_WAKE_CURRENT = 8'h40;
    // Monitor level in 0.1 V steps: 3.4 V default, 2.4 V floor
    localparam logic [5:0] PMG_MON_LEVEL_RESET = 6'h22;
    localparam logic [5:0] PMG_MON_LEVEL_MIN = 6'h18;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {PMG_OFF, PMG_STANDBY, PMG_ACTIVE, PMG_PIN_WAKE} pmg_mode_t;
    typedef enum logic [1:0] {PMG_RAMP_UP, PMG_ON_HOLD, PMG_RAMP_DOWN, PMG_OFF_HOLD} pmg_phase_t;

    typedef struct packed {
        logic charge_pump;
        logic [3:0] current;
        logic pattern;
        logic ext_pwm;
    } pmg_blocks_t;

    typedef struct packed {
        logic wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pmg_reg_req_t;

endpackage

// file: dv/pmg_power_ctrl_sva.sv
// Checker for the power mode and shared pin block.
// Sees only the top ports and is bound in below.
`timescale 1ns/10ps
module pmg_power_ctrl_sva
    import pmg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Inputs watched
    input wire logic scl_level,
    input wire logic sda_level,
    input wire logic supply_above_cutoff,
    input wire pmg_reg_req_t reg_req,
    // Outputs watched
    input wire pmg_mode_t mode,
    input wire logic bus_if_enable,
    input wire pmg_blocks_t block_enable,
    input wire logic [5:0] supply_monitor_level,
    input wire logic led_one_wake_sel,
    input wire logic [7:0] led_one_wake_current,
    input wire logic [7:0] led_one_wake_level,
    input wire logic shared_pin_out,
    input wire logic shared_pin_oe,
    input wire logic shared_pin_digital_en,
    input wire logic shared_pin_pulldown_en
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_blocks_off_idle: assert property (mode != PMG_ACTIVE && $past(mode) != PMG_ACTIVE |-> block_enable == '0)
        else $error("block enabled outside active mode");
    a_pin_no_high: assert property (shared_pin_out == 1'b0)
        else $error("shared pin driven high");
    a_oe_needs_write: assert property ($rose(shared_pin_oe) |-> $past(reg_req.wr_en, 2))
        else $error("pin pull-down began without a write");
    a_cutoff_to_off: assert property (!supply_above_cutoff |-> ##[1:3] mode == PMG_OFF)
        else $error("supply cutoff did not force off");
    a_wake_current: assert property (led_one_wake_sel |-> led_one_wake_current == PMG_WAKE_CURRENT)
        else $error("wake current wrong");
    a_wake_sel_mode: assert property (mode == PMG_PIN_WAKE |-> led_one_wake_sel)
        else $error("pin wake without channel one pattern");
    // Brightness moves one step at a time inside the wake pattern
    a_ramp_step: assert property (mode == PMG_PIN_WAKE && $past(mode) == PMG_PIN_WAKE && $changed(led_one_wake_level)
        |-> led_one_wake_level == $past(led_one_wake_level) + 8'h01
        || led_one_wake_level == $past(led_one_wake_level) - 8'h01)
        else $error("pattern level jumped");
    a_audio_no_pull: assert property (!shared_pin_digital_en |-> !shared_pin_pulldown_en)
        else $error("pull-down on in audio mode");
    a_monitor_floor: assert property (supply_monitor_level >= PMG_MON_LEVEL_MIN)
        else $error("monitor level below floor");
    a_standby_debounced: assert property ($past(mode) == PMG_OFF && mode == PMG_STANDBY
        |-> $past(scl_level, 8) && $past(sda_level, 8))
        else $error("standby entered without debounced lines");
    a_off_no_bus: assert property (mode == PMG_OFF && $past(mode) == PMG_OFF |-> !bus_if_enable)
        else $error("bus interface on while off");

    c_pin_wake: cover property (mode == PMG_PIN_WAKE);
    c_standby: cover property (mode == PMG_STANDBY);
    c_active: cover property (mode == PMG_ACTIVE);
    c_oe_rose: cover property ($rose(shared_pin_oe));
endmodule

bind pmg_power_ctrl pmg_power_ctrl_sva u_sva (.clk(clk), .rst(rst), .scl_level(scl_level), .sda_level(sda_level),
    .supply_above_cutoff(supply_above_cutoff), .reg_req(reg_req), .mode(mode), .bus_if_enable(bus_if_enable),
    .block_enable(block_enable), .supply_monitor_level(supply_monitor_level), .led_one_wake_sel(led_one_wake_sel),
    .led_one_wake_current(led_one_wake_current), .led_one_wake_level(led_one_wake_level),
    .shared_pin_out(shared_pin_out), .shared_pin_oe(shared_pin_oe),
    .shared_pin_digital_en(shared_pin_digital_en), .shared_pin_pulldown_en(shared_pin_pulldown_en));

// file: dv/pmg_far_side.sv
// Far side model: bus host lines and an open-drain charger on the shared pin.
// Assumes an external pull-up on the pin; slow mode lags the charger a cycle.
`timescale 1ns/10ps
module pmg_far_side (
    // Bench control
    input wire logic clk,
    input wire logic host_up,
    input wire logic charger_low,
    input wire logic slow,
    // Device side
    input wire logic dut_pin_oe,
    output logic scl_level,
    output logic sda_level,
    output logic pin_level
);
    // ----------------------------------------
    // Wires
    // ----------------------------------------
    logic charger_q;
    always_ff @(posedge clk) begin
        charger_q <= charger_low;
    end
    assign scl_level = host_up;
    assign sda_level = host_up;
    // Any party pulling low wins, else the pull-up reads high
    assign pin_level = !(dut_pin_oe || (slow ? charger_q : charger_low));
endmodule

// file: dv/pmg_power_ctrl_tb.sv
// Self-checking bench for the power mode and shared pin block.
// Short timing parameters; inputs change at the falling edge.
`timescale 1ns/10ps
module pmg_power_ctrl_tb;
    import pmg_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int DEB = 20;
    logic clk, rst, scl, sda, pin, host_up, slow, rd_mark, rd_d;
    logic charger_low = 1'b1;
    logic cut_ok = 1'b1;
    logic mon_ok = 1'b1;
    logic mon_en = 1'b0;
    logic [5:0] mon_cfg = 6'h22;
    logic [3:0] pwm_sel = 4'hF;
    pmg_blocks_t block_cfg = '0;
    pmg_reg_req_t reg_req = '0;
    pmg_blocks_t block_enable;
    pmg_mode_t mode;
    logic [7:0] reg_rdata, wake_cur, wake_lvl, v;
    logic [5:0] mon_lvl;
    logic [3:0] gate;
    logic bus_en, mon_on, sup_low, wake_sel, pin_out, pin_oe, dig_en, pd_en;
    logic [7:0] exp_q[$];
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;

    pmg_power_ctrl #(.DEBOUNCE_CYC(DEB), .RAMP_CYC(510), .ON_CYC(10), .OFF_CYC(10)) DUT (.clk(clk), .rst(rst),
        .scl_level(scl), .sda_level(sda), .shared_pin_in(pin), .supply_above_cutoff(cut_ok),
        .supply_above_monitor(mon_ok), .block_cfg(block_cfg), .ext_pwm_channel_sel(pwm_sel),
        .monitor_enable(mon_en), .monitor_level_cfg(mon_cfg), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .mode(mode), .bus_if_enable(bus_en), .block_enable(block_enable), .supply_monitor_on(mon_on),
        .supply_monitor_level(mon_lvl), .supply_low(sup_low), .led_pwm_gate(gate), .led_one_wake_sel(wake_sel),
        .led_one_wake_current(wake_cur), .led_one_wake_level(wake_lvl), .shared_pin_out(pin_out),
        .shared_pin_oe(pin_oe), .shared_pin_digital_en(dig_en), .shared_pin_pulldown_en(pd_en));
    pmg_far_side u_far (.clk(clk), .host_up(host_up), .charger_low(charger_low), .slow(slow),
        .dut_pin_oe(pin_oe), .scl_level(scl), .sda_level(sda), .pin_level(pin));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic compare(string name, logic [7:0] e, logic [7:0] got);
        check_count++;
        if (got !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, e, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk);
        reg_req <= '{wr_en: 1'b1, addr: a, wdata: d};
        @(negedge clk);
        reg_req.wr_en <= 1'b0;
    endtask
    // Read data is registered, so the note waits one edge for the monitor
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(negedge clk);
        reg_req.addr <= a;
        rd_mark <= 1'b1;
        exp_q.push_back(e);
        @(negedge clk);
        rd_mark <= 1'b0;
    endtask
    task automatic wait_for(bit lvl, logic [7:0] e, int lim);
        for (int i = 0; i < lim && (lvl ? wake_lvl : 8'(mode)) !== e; i++) begin
            @(negedge clk);
        end
        compare(lvl ? "wake_lvl" : "mode", e, lvl ? wake_lvl : 8'(mode));
    endtask

    always @(posedge clk) begin
        if (rd_d) begin
            compare("reg_rdata", exp_q.pop_front(), reg_rdata);
        end
        rd_d <= rd_mark;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            end_sim();
        end
    end
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        host_up = 1'b0;
        slow = 1'b0;
        rd_mark = 1'b0;
        void'($urandom(86968));
        repeat (5) @(negedge clk);
        rst = 1'b0;
        compare("mode", 8'(PMG_OFF), 8'(mode));
        compare("dig_en", 8'h01, 8'(dig_en));
        compare("pin_oe", 8'h00, 8'(pin_oe));
        compare("mon_lvl", 8'(PMG_MON_LEVEL_RESET), 8'(mon_lvl));
        charger_low = 1'b0;
        wait_for(0, 8'(PMG_PIN_WAKE), 10);
        compare("wake_cur", PMG_WAKE_CURRENT, wake_cur);
        wait_for(1, 8'hFF, 600);
        wait_for(1, 8'h00, 600);
        wait_for(1, 8'hFF, 600);
        charger_low = 1'b1;
        wait_for(0, 8'(PMG_OFF), 5);
        host_up = 1'b1;
        repeat (DEB / 2) @(negedge clk);
        compare("mode", 8'(PMG_OFF), 8'(mode));
        wait_for(0, 8'(PMG_STANDBY), DEB + 10);
        compare("bus_en", 8'h01, 8'(bus_en));
        rd(PMG_OFS_PIN_CTRL, PMG_CTRL_RESET);
        rd(PMG_OFS_PIN_OUT, PMG_OUT_RESET);
        wr(PMG_OFS_PIN_LEVEL, 8'hFF);
        rd(PMG_OFS_PIN_LEVEL, 8'h00);
        rd(8'h10, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            wr(PMG_OFS_PIN_CTRL, {5'h0, v[2], i[0], 1'b0});
            rd(PMG_OFS_PIN_CTRL, {5'h0, v[2], i[0], 1'b0});
            compare("pd_en", 8'(i[0]), 8'(pd_en));
        end
        slow = 1'b1;
        for (int k = 0; k < 4; k++) begin
            charger_low = k[0];
            wr(PMG_OFS_PIN_CTRL, {5'h0, k[1], 2'b10});
            repeat (3) @(negedge clk);
            rd(PMG_OFS_PIN_LEVEL, {7'h0, !k[0] ^ k[1]});
        end
        slow = 1'b0;
        charger_low = 1'b0;
        wr(PMG_OFS_PIN_CTRL, 8'h03);
        wr(PMG_OFS_PIN_OUT, 8'h00);
        @(negedge clk);
        compare("pin_oe", 8'h01, 8'(pin_oe));
        repeat (3) @(negedge clk);
        rd(PMG_OFS_PIN_LEVEL, 8'h00);
        wr(PMG_OFS_PIN_OUT, 8'h01);
        @(negedge clk);
        compare("pin_oe", 8'h00, 8'(pin_oe));
        compare("pin_out", 8'h00, 8'(pin_out));
        wr(PMG_OFS_PIN_CTRL, 8'h02);
        mon_en = 1'b1;
        mon_cfg = 6'h10;
        mon_ok = 1'b0;
        repeat (3) @(negedge clk);
        compare("mon_lvl", 8'h18, 8'(mon_lvl));
        compare("sup_low", 8'h01, 8'(sup_low));
        compare("mon_on", 8'h01, 8'(mon_on));
        mon_cfg = 6'h1C;
        mon_en = 1'b0;
        repeat (3) @(negedge clk);
        compare("mon_lvl", 8'h1C, 8'(mon_lvl));
        // Pin is released and high here, so the gate passes exactly the selected channels
        pwm_sel = 4'($urandom);
        block_cfg = pmg_blocks_t'($urandom) | 7'h03;
        wait_for(0, 8'(PMG_ACTIVE), 5);
        @(negedge clk);
        compare("blocks", 8'(block_cfg), 8'(block_enable));
        compare("gate", 8'(pwm_sel), 8'(gate));
        host_up = 1'b0;
        repeat (DEB + 10) @(negedge clk);
        compare("mode", 8'(PMG_ACTIVE), 8'(mode));
        charger_low = 1'b1;
        wait_for(0, 8'(PMG_OFF), DEB + 10);
        block_cfg = '0;
        host_up = 1'b1;
        wait_for(0, 8'(PMG_STANDBY), DEB + 10);
        cut_ok = 1'b0;
        wait_for(0, 8'(PMG_OFF), 4);
        cut_ok = 1'b1;
        repeat (3) @(negedge clk);
        end_sim();
    end
endmodule
